// [rtl/lspd_map.vh]
// Timing constants for the linear sensor pulse driver
`ifndef LSPD_MAP_VH
`define LSPD_MAP_VH
// Slot bounds below are inclusive slot numbers within one pixel
`define LSPD_PIXEL_CYCLES 3'h6
`define LSPD_START_CYCLES 2'h2
`define LSPD_PH1_BEGIN 3'h0
`define LSPD_PH1_END 3'h1
`define LSPD_RST_BEGIN 3'h4
`define LSPD_RST_END 3'h0
`define LSPD_TRIG_BEGIN 3'h3
`define LSPD_TRIG_END 3'h5
`define LSPD_EOS_CYCLES 3'h4
`define LSPD_SLOT_AFTER_RST 3'h1
`define LSPD_PIXELS_DEF 1024
`endif

// [rtl/lspd_sync.v]
// Two-flop synchroniser for an asynchronous input level
`timescale 1ns/100ps
module lspd_sync (
	input wire clk_sys_i,
	input wire rst_i,
	input wire async_i,
	output wire sync_o
);
	reg meta_q;
	reg sync_q;
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end
	assign sync_o = sync_q;
endmodule // lspd_sync

// [rtl/lspd_top.v]
// Pulse generator for a voltage-output linear image sensor
// Overview of operation
// - Drive sensor start pulse, two-phase clocks and reset pulse.
// - All outputs synchronous to the master clock only.
// - Master start pulse reinitialises the pulse sequence.
// - Active-high trigger marks the sample-and-hold capture moment.
// - End of scan aligned with phase two after the last pixel.
// - End of scan is active low; trigger active high.
// - Start pulse on master start fall, high two clocks.
// - Each pixel lasts six master clocks.
// - Complementary phases: phase one high two, phase two high four clocks.
// - Reset high three clocks, two overlap phase two, falls before phase two rises.
`timescale 1ns/100ps
`include "lspd_map.vh"
module lspd_top #(
	parameter PIXELS = `LSPD_PIXELS_DEF
) (
	// Clock and reset
	input wire clk_sys_i,
	input wire rst_i,
	// Master start from outside
	input wire master_start_in_i,
	// Sensor drive
	output reg sensor_scan_start_o,
	output reg phase1_o,
	output reg phase2_o,
	output reg sensor_reset_o,
	// Converter side
	output reg trigger_o,
	output reg scan_done_n_o
);
	localparam ST_IDLE = 1'b0;
	localparam ST_SCAN = 1'b1;
	localparam [2:0] PH_LAST = `LSPD_PIXEL_CYCLES - 3'h1;
	localparam [1:0] ST_LOAD = `LSPD_START_CYCLES - 2'h1;
	localparam [2:0] EOS_LOAD = `LSPD_EOS_CYCLES;
	localparam [31:0] PIX_LAST = PIXELS - 1;

	wire start_s;
	wire start_fall;
	wire [2:0] nx_slot;
	wire last_slot_end;
	reg start_prev_q;
	reg state_q;
	reg [2:0] phase_q;
	reg [15:0] pix_q;
	reg [1:0] st_cnt_q;
	reg [2:0] eos_cnt_q;

	// Slot that the outputs show after the coming edge
	function [2:0] next_slot;
		input restart;
		input [2:0] slot;
		begin
			if (restart) begin
				next_slot = 3'h0;
			end else if (slot == PH_LAST) begin
				next_slot = 3'h0;
			end else begin
				next_slot = slot + 3'h1;
			end
		end
	endfunction

	// True when a slot lies in an inclusive window
	function slot_in;
		input [2:0] slot;
		input [2:0] first;
		input [2:0] last;
		begin
			slot_in = (slot >= first) && (slot <= last);
		end
	endfunction

	// Same, for a window that wraps past the end of the pixel
	function slot_in_wrap;
		input [2:0] slot;
		input [2:0] first;
		input [2:0] last;
		begin
			slot_in_wrap = (slot >= first) || (slot <= last);
		end
	endfunction

	// Master start is a pin, so it is synchronised first
	lspd_sync u_sync (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.async_i(master_start_in_i),
		.sync_o(start_s)
	);

	assign start_fall = start_prev_q & ~start_s;
	assign nx_slot = next_slot(start_fall, phase_q);
	assign last_slot_end = (state_q == ST_SCAN) && (phase_q == PH_LAST) && ({16'h0000, pix_q} == PIX_LAST);

	// Edge detector; resets low so no false fall follows reset
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			start_prev_q <= 1'b0;
		end else begin
			start_prev_q <= start_s;
		end
	end

	// Pixel slot: 0..1 phase one, 2..5 phase two
	// Reset parks the slot so the first slot after release is a whole phase-two slot
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			phase_q <= `LSPD_SLOT_AFTER_RST;
		end else begin
			phase_q <= nx_slot;
		end
	end

	// Scan state and pixel counter
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
			pix_q <= 16'h0000;
		end else if (start_fall) begin
			state_q <= ST_SCAN;
			pix_q <= 16'h0000;
		end else if (last_slot_end) begin
			state_q <= ST_IDLE;
		end else if ((state_q == ST_SCAN) && (phase_q == PH_LAST)) begin
			pix_q <= pix_q + 16'h0001;
		end
	end

	// Sensor start pulse: two clocks from the master start fall
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			st_cnt_q <= 2'h0;
			sensor_scan_start_o <= 1'b0;
		end else if (start_fall) begin
			st_cnt_q <= ST_LOAD;
			sensor_scan_start_o <= 1'b1;
		end else if (st_cnt_q != 2'h0) begin
			st_cnt_q <= st_cnt_q - 2'h1;
		end else begin
			sensor_scan_start_o <= 1'b0;
		end
	end

	// Complementary shift-register clocks
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			phase1_o <= 1'b0;
			phase2_o <= 1'b0;
		end else begin
			phase1_o <= slot_in(nx_slot, `LSPD_PH1_BEGIN, `LSPD_PH1_END);
			phase2_o <= ~slot_in(nx_slot, `LSPD_PH1_BEGIN, `LSPD_PH1_END);
		end
	end

	// Sensor reset pulse: slots 4, 5 and 0, so it falls before phase two rises
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			sensor_reset_o <= 1'b0;
		end else begin
			sensor_reset_o <= slot_in_wrap(nx_slot, `LSPD_RST_BEGIN, `LSPD_RST_END);
		end
	end

	// Converter trigger, rising one clock after phase two
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			trigger_o <= 1'b0;
		end else begin
			trigger_o <= slot_in(nx_slot, `LSPD_TRIG_BEGIN, `LSPD_TRIG_END);
		end
	end

	// End of scan: armed at the end of the last pixel, low over the phase-two
	// slots 2..5 of the following pixel period; a restart drops it
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			eos_cnt_q <= 3'h0;
			scan_done_n_o <= 1'b1;
		end else if (start_fall) begin
			eos_cnt_q <= 3'h0;
			scan_done_n_o <= 1'b1;
		end else if ((eos_cnt_q != 3'h0) && !slot_in(nx_slot, `LSPD_PH1_BEGIN, `LSPD_PH1_END)) begin
			eos_cnt_q <= eos_cnt_q - 3'h1;
			scan_done_n_o <= 1'b0;
		end else if (last_slot_end) begin
			eos_cnt_q <= EOS_LOAD;
			scan_done_n_o <= 1'b1;
		end else begin
			scan_done_n_o <= 1'b1;
		end
	end
endmodule // lspd_top

// [dv/lspd_adc_mdl.sv]
// Converter side model
`timescale 1ns/100ps
module lspd_adc_mdl(input wire scan_done_n_o);
integer scans=0;
always @(negedge scan_done_n_o) scans=scans+1;
endmodule // lspd_adc_mdl

// [dv/lspd_top_chk.sv]
// Port checks
`timescale 1ns/100ps
module lspd_chk(input wire clk_sys_i,rst_i,master_start_in_i,sensor_scan_start_o,phase1_o,phase2_o,sensor_reset_o,
trigger_o,scan_done_n_o);
wire s=sensor_scan_start_o,a=phase1_o,b=phase2_o,r=sensor_reset_o,t=trigger_o,d=scan_done_n_o;
default clocking @(posedge clk_sys_i); endclocking
// A restart may cut a pixel short
default disable iff (rst_i||s);
a_start_len: assert property ($fell(s)|->$past(s,2)&&!$past(s,3)) else $error("start");
a_phase_compl: assert property (!$past(rst_i)|->a^b) else $error("phases");
a_ph1_len: assert property ($rose(a)|->a[*2]##1!a) else $error("phase1");
a_ph2_len: assert property ($rose(b)|->b[*4]##1!b) else $error("phase2");
a_rst_len: assert property ($rose(r)|->r[*3]##1!r##1$rose(b)) else $error("reset");
a_trig_pos: assert property ($rose(b)|=>$rose(t)##1t[*2]##1!t) else $error("trigger");
a_trig_in: assert property (t|->b) else $error("trig");
a_done_len: assert property ($fell(d)|->(!d)[*4]##1d) else $error("scan end");
a_done_align: assert property ($fell(d)|->$rose(b)) else $error("scan end align");
endmodule // lspd_chk
bind lspd_top lspd_chk u_chk(.*);

// [dv/tb.sv]
// Sensor driver bench
`timescale 1ns/100ps
module tb;
localparam integer PIX = 4;
reg clk_sys_i=0,rst_i=1,master_start_in_i=1,rst_q=1;
wire sensor_scan_start_o,phase1_o,phase2_o,sensor_reset_o,trigger_o,scan_done_n_o;
reg [31:0] x=32'h0001152c;
reg [7:0] exp_v,seen_v;
integer error_cnt=0,num_checks=0,k=9,p=0,since=0;
always #2.5 clk_sys_i=~clk_sys_i;
lspd_top #(.PIXELS(PIX)) u_lspd_top(.*);
lspd_adc_mdl u_mdl(.*);
task w(input integer n); repeat(n) @(negedge clk_sys_i); endtask
task f(input integer n); begin master_start_in_i=0; since=0; w(n); master_start_in_i=1; end endtask
task c(input [8*8:1] nm, input [7:0] v,u); begin num_checks++;
	if (v!==u) begin error_cnt++; $display("ERROR %0s expected %h seen %h",nm,v,u); end end endtask
// Reset and clocks since the last master start fall, taken at the rising edge
always @(posedge clk_sys_i) begin rst_q<=rst_i; since=since+1; end
task tally_and_finish; begin $display("checks %0d errors %0d",num_checks,error_cnt);
	if (error_cnt==0&&num_checks>0) $display("TEST PASSED");
	else $display("TEST FAILED");
	$finish; end endtask
// Slot model anchored on each start pulse
always @(negedge clk_sys_i) begin
	if (rst_q) begin k=9; p=0; end
	else if ($rose(sensor_scan_start_o)) begin k=0; p=0; c("latency",8'h03,since[7:0]); end
	else if (k<6) begin if (k==5) p=p+1; k=(k+1)%6; end
	exp_v={2'b00,k<2&&p==0,k<2,k>1,k>3||k==0,k>2,!(p==PIX&&k>1)};
	seen_v={2'b00,sensor_scan_start_o,phase1_o,phase2_o,sensor_reset_o,trigger_o,scan_done_n_o};
	if (k<6) c("outputs",exp_v,seen_v);
end
initial begin
	w(20); rst_i=0; w(3); f(8); w(40); c("scans",8'h01,u_mdl.scans[7:0]);
	$display("scan end");
	repeat(8) begin x=x^x<<13; x=x^x>>17; x=x^x<<5; f(6+x%5); w(2+x%9); end
	$display("restart end");
	rst_i=1; w(1); rst_i=0; w(3); f(6); w(40); c("scans",8'h02,u_mdl.scans[7:0]);
	$display("reset end");
	tally_and_finish;
end
initial begin #5000; error_cnt++; tally_and_finish; end
endmodule // tb
